//--- omsm_pkg.sv
package omsm_pkg;

  // operating modes; active modes reuse the command codes
  typedef enum logic [2:0] {
    OMSM_OFF      = 3'b000,
    OMSM_SLEEP    = 3'b001,
    OMSM_OVERTEMP = 3'b010,
    OMSM_STANDBY  = 3'b100,
    OMSM_NORMAL   = 3'b111
  } omsm_mode_t;

  // mode select field commands
  localparam logic [2:0] CMD_SLEEP   = 3'h1;
  localparam logic [2:0] CMD_STANDBY = 3'h4;
  localparam logic [2:0] CMD_NORMAL  = 3'h7;

  // register addresses and field positions
  localparam logic [6:0] ADDR_MODE_CTRL   = 7'h01;
  localparam logic [6:0] ADDR_MAIN_STATUS = 7'h03;
  localparam int         MODE_SEL_MSB     = 2;
  localparam int         MODE_SEL_LSB     = 0;
  localparam int         SLEEP_CAUSE_BIT  = 7;
  localparam int         OTW_STATE_BIT    = 6;
  localparam int         NMS_BIT          = 5;

  // serial frame: 7 address bits, read-only flag, 8 data bits
  localparam int         FRAME_BITS       = 16;
  localparam logic [4:0] FRAME_LAST       = 5'h0f;
  localparam logic [4:0] FRAME_ADDR_DONE  = 5'h07;
  localparam logic [4:0] FRAME_FULL       = 5'h10;

  // reset values
  localparam logic       RST_BUS_WAKE_EN  = 1'b0;
  localparam logic       RST_LOCAL_WK_EN  = 1'b0;
  localparam logic       RST_PN_EN        = 1'b0;
  localparam logic       RST_NMS          = 1'b1;
  localparam logic       RST_SLEEP_CAUSE  = 1'b0;

  // start-up delay
  localparam int         CLK_KHZ          = 20000;
  localparam int         T_STARTUP_US     = 50;
  localparam int         STARTUP_CYC      = (T_STARTUP_US * CLK_KHZ) / 1000;
  localparam logic [10:0] STARTUP_LAST    = 11'(STARTUP_CYC - 1);

endpackage

//--- omsm_sync.sv
`timescale 1ns/1ps
`default_nettype none

module omsm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      // first stage feeds only the second
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          meta_q[b] <= 1'b0;
          sync_q[b] <= 1'b0;
        end else begin
          meta_q[b] <= async_i[b];
          sync_q[b] <= meta_q[b];
        end
      end
    end
  endgenerate

  assign sync_o = sync_q;

endmodule

`default_nettype wire

//--- omsm_spi_link.sv
`timescale 1ns/1ps
`default_nettype none

module omsm_spi_link (
  input  wire logic       spi_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       serial_chip_select_n_i,
  input  wire logic       serial_data_in_i,
  output logic            serial_data_out_o,
  output logic            serial_data_out_oe_o,
  input  wire logic [7:0] rd_mode_i,
  input  wire logic [7:0] rd_status_i,
  output logic            wr_tog_o,
  output logic [2:0]      wr_data_o
);
  import omsm_pkg::*;

  // clock stops between frames, so chip select ends the frame
  logic        frm_rst_n;
  logic [4:0]  cnt_q;
  logic [14:0] sh_q;
  logic [7:0]  out_q;
  logic [15:0] rb_meta_q;
  logic [15:0] rb_q;
  logic        tog_q;
  logic [2:0]  data_q;
  logic [6:0]  rd_addr_w;
  logic [7:0]  rd_byte_w;
  logic        wr_hit_w;

  assign frm_rst_n = nrst_i & ~serial_chip_select_n_i;
  assign rd_addr_w = sh_q[6:0];
  assign rd_byte_w = (rd_addr_w == ADDR_MODE_CTRL)   ? rb_q[15:8] :
                     (rd_addr_w == ADDR_MAIN_STATUS) ? rb_q[7:0]  : 8'h00;
  assign wr_hit_w  = (cnt_q == FRAME_LAST) && !sh_q[7] &&
                     (sh_q[14:8] == ADDR_MODE_CTRL);

  always_ff @(posedge spi_clk_i or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      cnt_q <= 5'h00;
      sh_q  <= 15'h0000;
      out_q <= 8'h00;
    end else begin
      sh_q <= {sh_q[13:0], serial_data_in_i};
      if (cnt_q != FRAME_FULL) begin
        cnt_q <= cnt_q + 5'h01;
      end
      if (cnt_q == FRAME_ADDR_DONE) begin
        out_q <= rd_byte_w;
      end else begin
        out_q <= {out_q[6:0], 1'b0};
      end
    end
  end

  // status bytes change slowly; first two edges settle the sync
  always_ff @(posedge spi_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rb_meta_q <= 16'h0000;
      rb_q      <= 16'h0000;
      tog_q     <= 1'b0;
      data_q    <= 3'h0;
    end else begin
      rb_meta_q <= {rd_mode_i, rd_status_i};
      rb_q      <= rb_meta_q;
      if (wr_hit_w) begin
        data_q <= {sh_q[1:0], serial_data_in_i};
        tog_q  <= ~tog_q;
      end
    end
  end

  assign serial_data_out_o    = out_q[7];
  assign serial_data_out_oe_o = ~serial_chip_select_n_i;
  assign wr_tog_o             = tog_q;
  assign wr_data_o            = data_q;

endmodule

`default_nettype wire

//--- omsm_top.sv
`timescale 1ns/1ps
`default_nettype none

module omsm_top (
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  input  wire logic               spi_clk_i,
  input  wire logic               serial_chip_select_n_i,
  input  wire logic               serial_data_in_i,
  output logic                    serial_data_out_o,
  output logic                    serial_data_out_oe_o,
  input  wire logic               battery_supply_low_i,
  input  wire logic               vcc_uv_i,
  input  wire logic               io_supply_uv_i,
  input  wire logic               otp_activate_i,
  input  wire logic               otp_release_i,
  input  wire logic               otp_warning_i,
  input  wire logic               local_wake_i,
  input  wire logic               can_rx_i,
  input  wire logic               bus_wake_pattern_i,
  input  wire logic               bus_wake_frame_i,
  input  wire logic               other_irq_i,
  input  wire logic               spi_failure_event_i,
  input  wire logic               wake_cfg_load_i,
  input  wire logic               bus_wake_enable_i,
  input  wire logic               local_wake_falling_enable_i,
  input  wire logic               local_wake_rising_enable_i,
  input  wire logic               partial_net_enable_i,
  input  wire logic               partial_net_config_valid_i,
  input  wire logic               overtemp_warning_irq_enable_i,
  input  wire logic               wake_clear_i,
  input  wire logic               overtemp_warning_clear_i,
  output omsm_pkg::omsm_mode_t    mode_o,
  output logic [2:0]              wake_pending_o,
  output logic                    bus_wake_enable_o,
  output logic                    local_wake_falling_enable_o,
  output logic                    local_wake_rising_enable_o,
  output logic                    partial_net_enable_o,
  output logic                    sleep_cause_flag_o,
  output logic                    overtemp_warning_state_o,
  output logic                    overtemp_warning_event_o,
  output logic                    normal_mode_pending_o,
  output logic                    regulator_inhibit_output_o,
  output logic                    regulator_inhibit_output_oe_o,
  output logic                    can_active_o,
  output logic                    can_bias_o,
  output logic                    rxd_o
);
  import omsm_pkg::*;

  // synchronised pins and link toggle
  logic [10:0] raw_w;
  logic [10:0] syn_w;
  logic        wr_tog_w;
  logic [2:0]  wr_data_w;
  logic        batt_low_w;
  logic        uv_w;
  logic        io_uv_w;
  logic        otp_act_w;
  logic        otp_rel_w;
  logic        otw_w;
  logic        lw_w;
  logic        rx_w;
  logic        bus_pat_w;
  logic        bus_frm_w;
  logic        tog_s_w;

  // state
  omsm_mode_t  mode_q;
  omsm_mode_t  mode_d;
  logic [10:0] start_cnt_q;
  logic        tog_seen_q;
  logic        lw_prev_q;
  logic        otw_prev_q;
  logic [2:0]  pend_q;
  logic        bus_we_q;
  logic        lwf_en_q;
  logic        lwr_en_q;
  logic        pn_en_q;
  logic        cause_q;
  logic        otw_flag_q;
  logic        nms_q;
  logic        inh_oe_q;
  logic        can_act_q;
  logic        can_bias_q;
  logic        rxd_q;

  // decode
  logic        cmd_w;
  logic        detect_w;
  logic        sel_wake_w;
  logic        bus_hit_w;
  logic [2:0]  pend_set_w;
  logic        irq_w;
  logic        sleep_exit_w;
  logic        any_event_w;
  logic        src_en_w;
  logic        uv_force_w;
  logic        spi_sleep_w;
  logic        otw_rise_w;
  logic        start_done_w;
  logic [7:0]  rd_mode_w;
  logic [7:0]  rd_status_w;

  assign raw_w = {wr_tog_w, bus_wake_frame_i, bus_wake_pattern_i,
                  can_rx_i, local_wake_i, otp_warning_i, otp_release_i,
                  otp_activate_i, io_supply_uv_i, vcc_uv_i,
                  battery_supply_low_i};

  omsm_sync #(
    .W (11)
  ) u_sync (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .async_i (raw_w),
    .sync_o  (syn_w)
  );

  assign batt_low_w = syn_w[0];
  assign io_uv_w    = syn_w[2];
  assign uv_w       = syn_w[1] | syn_w[2];
  assign otp_act_w  = syn_w[3];
  assign otp_rel_w  = syn_w[4];
  assign otw_w      = syn_w[5];
  assign lw_w       = syn_w[6];
  assign rx_w       = syn_w[7];
  assign bus_pat_w  = syn_w[8];
  assign bus_frm_w  = syn_w[9];
  assign tog_s_w    = syn_w[10];

  omsm_spi_link u_link (
    .spi_clk_i              (spi_clk_i),
    .nrst_i                 (nrst_i),
    .serial_chip_select_n_i (serial_chip_select_n_i),
    .serial_data_in_i       (serial_data_in_i),
    .serial_data_out_o      (serial_data_out_o),
    .serial_data_out_oe_o   (serial_data_out_oe_o),
    .rd_mode_i              (rd_mode_w),
    .rd_status_i            (rd_status_w),
    .wr_tog_o               (wr_tog_w),
    .wr_data_o              (wr_data_w)
  );

  // data word settled long before its toggle arrives here
  assign cmd_w = tog_s_w ^ tog_seen_q;

  // wake detection runs only in standby and sleep
  assign detect_w   = (mode_q == OMSM_STANDBY) || (mode_q == OMSM_SLEEP);
  assign sel_wake_w = pn_en_q & partial_net_config_valid_i;
  assign bus_hit_w  = bus_we_q & (sel_wake_w ? bus_frm_w : bus_pat_w);
  assign pend_set_w = {3{detect_w}} &
                      {bus_hit_w,
                       lwr_en_q & lw_w & ~lw_prev_q,
                       lwf_en_q & ~lw_w & lw_prev_q};

  // spi failure counts as an event but never ends sleep
  assign irq_w        = otw_flag_q | other_irq_i;
  assign sleep_exit_w = (|pend_q) | irq_w;
  assign any_event_w  = sleep_exit_w | spi_failure_event_i;
  assign src_en_w     = bus_we_q | lwf_en_q | lwr_en_q;
  assign otw_rise_w   = otw_w & ~otw_prev_q;
  assign start_done_w = (start_cnt_q == STARTUP_LAST);

  always_comb begin
    mode_d      = mode_q;
    uv_force_w  = 1'b0;
    spi_sleep_w = 1'b0;
    case (mode_q)
      OMSM_OFF: begin
        if (!batt_low_w && start_done_w) begin
          mode_d = OMSM_STANDBY;
        end
      end
      OMSM_NORMAL, OMSM_STANDBY: begin
        if (mode_q == OMSM_NORMAL && otp_act_w) begin
          mode_d = OMSM_OVERTEMP;
        end else if (uv_w) begin
          mode_d     = OMSM_SLEEP;
          uv_force_w = 1'b1;
        end else if (cmd_w && wr_data_w == CMD_NORMAL) begin
          mode_d = OMSM_NORMAL;
        end else if (cmd_w && wr_data_w == CMD_STANDBY) begin
          mode_d = OMSM_STANDBY;
        end else if (cmd_w && wr_data_w == CMD_SLEEP) begin
          if (!sleep_exit_w && src_en_w) begin
            mode_d      = OMSM_SLEEP;
            spi_sleep_w = 1'b1;
          end else begin
            mode_d = OMSM_STANDBY;
          end
        end
      end
      OMSM_SLEEP: begin
        // a command needs a live io supply to be heard
        if (cmd_w && !io_uv_w && wr_data_w == CMD_NORMAL) begin
          mode_d = OMSM_NORMAL;
        end else if (cmd_w && !io_uv_w && wr_data_w == CMD_STANDBY) begin
          mode_d = OMSM_STANDBY;
        end else if (sleep_exit_w) begin
          mode_d = OMSM_STANDBY;
        end
      end
      OMSM_OVERTEMP: begin
        if (otp_rel_w) begin
          mode_d = OMSM_STANDBY;
        end
      end
      default: begin
        mode_d = OMSM_OFF;
      end
    endcase
    if (batt_low_w) begin
      mode_d      = OMSM_OFF;
      uv_force_w  = 1'b0;
      spi_sleep_w = 1'b0;
    end
  end

  // other codes fall through every branch above

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_q <= OMSM_OFF;
    end else begin
      mode_q <= mode_d;
    end
  end

  // start-up delay restarts on every battery dip
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_cnt_q <= 11'h000;
    end else if (mode_q != OMSM_OFF || batt_low_w) begin
      start_cnt_q <= 11'h000;
    end else if (!start_done_w) begin
      start_cnt_q <= start_cnt_q + 11'h001;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tog_seen_q <= 1'b0;
      lw_prev_q  <= 1'b0;
      otw_prev_q <= 1'b0;
    end else begin
      tog_seen_q <= tog_s_w;
      lw_prev_q  <= lw_w;
      otw_prev_q <= otw_w;
    end
  end

  // pending wake: set beats clear, undervoltage wipes all
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_q <= 3'h0;
    end else if (uv_force_w) begin
      pend_q <= 3'h0;
    end else if (wake_clear_i) begin
      pend_q <= pend_set_w;
    end else begin
      pend_q <= pend_q | pend_set_w;
    end
  end

  // wake enables; forced values win over a host load
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_we_q <= RST_BUS_WAKE_EN;
      lwf_en_q <= RST_LOCAL_WK_EN;
      lwr_en_q <= RST_LOCAL_WK_EN;
      pn_en_q  <= RST_PN_EN;
    end else if (uv_force_w) begin
      bus_we_q <= 1'b1;
      lwf_en_q <= 1'b1;
      lwr_en_q <= 1'b1;
      pn_en_q  <= 1'b0;
    end else if (wake_cfg_load_i) begin
      bus_we_q <= bus_wake_enable_i;
      lwf_en_q <= local_wake_falling_enable_i;
      lwr_en_q <= local_wake_rising_enable_i;
      pn_en_q  <= partial_net_enable_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cause_q <= RST_SLEEP_CAUSE;
    end else if (uv_force_w) begin
      cause_q <= 1'b1;
    end else if (spi_sleep_w) begin
      cause_q <= 1'b0;
    end
  end

  // warning flag: a fresh edge wins over the clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      otw_flag_q <= 1'b0;
    end else if (otw_rise_w && overtemp_warning_irq_enable_i) begin
      otw_flag_q <= 1'b1;
    end else if (overtemp_warning_clear_i) begin
      otw_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nms_q <= RST_NMS;
    end else if (mode_q == OMSM_NORMAL) begin
      nms_q <= 1'b0;
    end
  end

  // pin controls follow the mode one cycle later
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      inh_oe_q   <= 1'b0;
      can_act_q  <= 1'b0;
      can_bias_q <= 1'b0;
      rxd_q      <= 1'b1;
    end else begin
      inh_oe_q   <= (mode_q != OMSM_OFF) && (mode_q != OMSM_SLEEP);
      can_act_q  <= (mode_q == OMSM_NORMAL);
      can_bias_q <= (mode_q != OMSM_OFF) && (mode_q != OMSM_OVERTEMP);
      case (mode_q)
        OMSM_NORMAL:   rxd_q <= rx_w;
        OMSM_STANDBY:  rxd_q <= ~any_event_w;
        OMSM_SLEEP:    rxd_q <= ~any_event_w;
        OMSM_OVERTEMP: rxd_q <= ~(|pend_q);
        default:       rxd_q <= 1'b1;
      endcase
    end
  end

  // readback bytes; reserved bits read as zero
  assign rd_mode_w   = {5'h00, mode_q};
  assign rd_status_w = {cause_q, otw_w, nms_q, 5'h00};

  assign mode_o                        = mode_q;
  assign wake_pending_o                = pend_q;
  assign bus_wake_enable_o             = bus_we_q;
  assign local_wake_falling_enable_o   = lwf_en_q;
  assign local_wake_rising_enable_o    = lwr_en_q;
  assign partial_net_enable_o          = pn_en_q;
  assign sleep_cause_flag_o            = cause_q;
  assign overtemp_warning_state_o      = otw_w;
  assign overtemp_warning_event_o      = otw_flag_q;
  assign normal_mode_pending_o         = nms_q;
  assign regulator_inhibit_output_o    = 1'b1;
  assign regulator_inhibit_output_oe_o = inh_oe_q;
  assign can_active_o                  = can_act_q;
  assign can_bias_o                    = can_bias_q;
  assign rxd_o                         = rxd_q;

endmodule

`default_nettype wire

//--- omsm_top_properties.sv
`timescale 1ns/1ps
`default_nettype none

module omsm_top_properties (
  input wire logic                 clk_i,
  input wire logic                 nrst_i,
  input wire logic                 battery_supply_low_i,
  input wire logic                 vcc_uv_i,
  input wire logic                 otp_activate_i,
  input wire omsm_pkg::omsm_mode_t mode_o,
  input wire logic [2:0]           wake_pending_o,
  input wire logic                 bus_wake_enable_o,
  input wire logic                 local_wake_falling_enable_o,
  input wire logic                 local_wake_rising_enable_o,
  input wire logic                 partial_net_enable_o,
  input wire logic                 sleep_cause_flag_o,
  input wire logic                 regulator_inhibit_output_oe_o,
  input wire logic                 can_active_o,
  input wire logic                 rxd_o
);
  import omsm_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // outputs are registered, so look only after the mode has settled
  sequence s_held(omsm_mode_t m);
    $past(mode_o) == m && mode_o == m;
  endsequence
  sequence s_uv_sleep;
    mode_o == OMSM_SLEEP && sleep_cause_flag_o && bus_wake_enable_o &&
    local_wake_falling_enable_o && local_wake_rising_enable_o &&
    !partial_net_enable_o && wake_pending_o == 3'h0;
  endsequence

  property p_legal;
    mode_o inside {OMSM_OFF, OMSM_SLEEP, OMSM_OVERTEMP, OMSM_STANDBY,
                   OMSM_NORMAL};
  endproperty
  property p_off_pins;
    s_held(OMSM_OFF) |-> !regulator_inhibit_output_oe_o && !can_active_o
                         && rxd_o;
  endproperty
  property p_sleep_pins;
    s_held(OMSM_SLEEP) |-> !regulator_inhibit_output_oe_o && !can_active_o;
  endproperty
  property p_stby_pins;
    s_held(OMSM_STANDBY) |-> regulator_inhibit_output_oe_o && !can_active_o;
  endproperty
  property p_ot_pins;
    s_held(OMSM_OVERTEMP) and $stable(wake_pending_o) |->
      regulator_inhibit_output_oe_o && !can_active_o &&
      rxd_o == ~|wake_pending_o;
  endproperty
  property p_bat_off;
    battery_supply_low_i |-> ##[1:4] mode_o == OMSM_OFF;
  endproperty
  property p_otp;
    mode_o == OMSM_NORMAL && otp_activate_i |->
      ##[1:4] mode_o inside {OMSM_OVERTEMP, OMSM_OFF};
  endproperty
  property p_uv;
    mode_o == OMSM_STANDBY && vcc_uv_i |-> ##[1:5] s_uv_sleep;
  endproperty
  property p_sleep_exit;
    mode_o == OMSM_SLEEP && wake_pending_o != 3'h0 |->
      ##[1:3] mode_o == OMSM_STANDBY;
  endproperty

  a_legal: assert property (p_legal) else $error("bad mode code");
  a_off_pins: assert property (p_off_pins) else $error("off pins");
  a_sleep_pins: assert property (p_sleep_pins) else $error("sleep");
  a_stby_pins: assert property (p_stby_pins) else $error("standby");
  a_ot_pins: assert property (p_ot_pins) else $error("overtemp");
  a_bat_off: assert property (p_bat_off) else $error("bat off");
  a_otp: assert property (p_otp) else $error("otp entry");
  a_uv: assert property (p_uv) else $error("uv sleep");
  a_sleep_exit: assert property (p_sleep_exit) else $error("wake");
endmodule

bind omsm_top omsm_top_properties u_props (.*);

`default_nettype wire

//--- omsm_spi_host.sv
`timescale 1ns/1ps
`default_nettype none

module omsm_spi_host (
  output var logic sck_o,
  output var logic cs_n_o,
  output var logic sdi_o,
  input  wire logic sdo_i
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end

  // clock stands low outside frames, 30 ns period inside
  task automatic xfer(input logic [6:0] a, input logic ro,
                      input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {a, ro, d};
    q = 8'h00;
    cs_n_o = 1'b0;
    #40;
    for (int i = 0; i < 16; i++) begin
      sdi_o = f[15-i];
      #15;
      sck_o = 1'b1;
      #15;
      if (i >= 7 && i < 15) begin
        q[14-i] = sdo_i;
      end
      sck_o = 1'b0;
    end
    #40;
    cs_n_o = 1'b1;
    // released line must not keep the last bit
    sdi_o = ~sdi_o;
    #100;
  endtask
endmodule

`default_nettype wire

//--- test_operating_mode_state_machine.sv
`timescale 1ns/1ps
`default_nettype none

module test_operating_mode_state_machine;
  import omsm_pkg::*;
  logic clk_i = 1'b0, nrst_i = 1'b0;
  logic spi_clk_i, serial_chip_select_n_i, serial_data_in_i;
  logic serial_data_out_o, serial_data_out_oe_o;
  logic battery_supply_low_i, vcc_uv_i, io_supply_uv_i, otp_activate_i;
  logic otp_release_i, otp_warning_i, local_wake_i, can_rx_i;
  logic bus_wake_pattern_i, bus_wake_frame_i, other_irq_i;
  logic spi_failure_event_i, wake_cfg_load_i, bus_wake_enable_i;
  logic local_wake_falling_enable_i, local_wake_rising_enable_i;
  logic partial_net_enable_i, partial_net_config_valid_i;
  logic overtemp_warning_irq_enable_i, wake_clear_i, overtemp_warning_clear_i;
  omsm_mode_t mode_o;
  logic [2:0] wake_pending_o;
  logic bus_wake_enable_o, local_wake_falling_enable_o;
  logic local_wake_rising_enable_o, partial_net_enable_o, sleep_cause_flag_o;
  logic overtemp_warning_state_o, overtemp_warning_event_o;
  logic normal_mode_pending_o, regulator_inhibit_output_o;
  logic regulator_inhibit_output_oe_o, can_active_o, can_bias_o, rxd_o;
  int fail_count = 0, checks = 0, cyc = 0;
  logic [7:0] q;
  logic [3:0] v;
  logic [2:0] bad [5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6};

  omsm_top dut (.*);
  omsm_spi_host u_host (.sck_o(spi_clk_i), .cs_n_o(serial_chip_select_n_i),
                        .sdi_o(serial_data_in_i), .sdo_i(serial_data_out_o));

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic md(input string s, input omsm_mode_t e);
    chk(s, 8'(e), 8'(mode_o));
  endtask
  task automatic cmd(input logic [2:0] c);
    u_host.xfer(ADDR_MODE_CTRL, 1'b0, {5'h00, c}, q);
    tick(8);
  endtask
  // readback may lag one frame, so the second read counts
  task automatic rd(input logic [6:0] a);
    u_host.xfer(a, 1'b1, 8'h00, q);
    u_host.xfer(a, 1'b1, 8'h00, q);
    tick(1);
  endtask
  task automatic load(input logic [3:0] e);
    tick(1);
    {bus_wake_enable_i, local_wake_falling_enable_i,
     local_wake_rising_enable_i, partial_net_enable_i} = e;
    wake_cfg_load_i = 1'b1;
    tick(1);
    wake_cfg_load_i = 1'b0;
  endtask
  // synced wake inputs linger two cycles; a clear before that is re-set
  task automatic wclr();
    tick(3);
    wake_clear_i = 1'b1;
    tick(1);
    wake_clear_i = 1'b0;
  endtask
  function automatic omsm_mode_t exp_sleep(input logic [3:0] e);
    return (|e[3:1]) ? OMSM_SLEEP : OMSM_STANDBY;
  endfunction

  initial begin
    {battery_supply_low_i, vcc_uv_i, io_supply_uv_i, otp_activate_i,
     otp_release_i, otp_warning_i, local_wake_i, can_rx_i,
     bus_wake_pattern_i, bus_wake_frame_i, other_irq_i, spi_failure_event_i,
     wake_cfg_load_i, bus_wake_enable_i, local_wake_falling_enable_i,
     local_wake_rising_enable_i, partial_net_enable_i,
     partial_net_config_valid_i, overtemp_warning_irq_enable_i,
     wake_clear_i, overtemp_warning_clear_i} = '0;
    void'($urandom(32'h92a80c79));
    tick(4);
    md("off", OMSM_OFF);
    chk("rxd", 8'h01, 8'(rxd_o));
    nrst_i = 1'b1;
    tick(STARTUP_CYC - 20);
    md("early", OMSM_OFF);
    tick(40);
    md("boot", OMSM_STANDBY);
    chk("inh", 8'h01, 8'(regulator_inhibit_output_oe_o));
    chk("inhv", 8'h01, 8'(regulator_inhibit_output_o));
    chk("bias", 8'h01, 8'(can_bias_o));
    chk("nms", 8'h01, 8'(normal_mode_pending_o));
    chk("sdoe", 8'h00, 8'(serial_data_out_oe_o));
    $display("test startup done");
    cmd(CMD_NORMAL);
    md("normal", OMSM_NORMAL);
    for (int i = 0; i < 6; i++) begin
      can_rx_i = 1'($urandom);
      tick(5);
      chk("rx", 8'(can_rx_i), 8'(rxd_o));
    end
    for (int i = 0; i < 5; i++) begin
      cmd(bad[i]);
      md("bad", OMSM_NORMAL);
    end
    rd(ADDR_MODE_CTRL);
    chk("mc", 8'h07, q);
    cmd(CMD_STANDBY);
    md("stby", OMSM_STANDBY);
    $display("test normal done");
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 4'h0 : (i == 1) ? 4'h8 : 4'($urandom);
      load(v);
      cmd(CMD_SLEEP);
      md("sleep", exp_sleep(v));
      if (mode_o === OMSM_SLEEP) begin
        chk("cause", 8'h00, 8'(sleep_cause_flag_o));
        chk("inh", 8'h00, 8'(regulator_inhibit_output_oe_o));
        cmd(CMD_STANDBY);
        md("wake", OMSM_STANDBY);
      end
    end
    load(4'h8);
    cmd(CMD_SLEEP);
    spi_failure_event_i = 1'b1;
    tick(4);
    md("spi_failure_event", OMSM_SLEEP);
    chk("rxd", 8'h00, 8'(rxd_o));
    spi_failure_event_i = 1'b0;
    bus_wake_pattern_i = 1'b1;
    tick(6);
    md("wk", OMSM_STANDBY);
    chk("pend", 8'h04, 8'(wake_pending_o));
    chk("rxd", 8'h00, 8'(rxd_o));
    bus_wake_pattern_i = 1'b0;
    wclr();
    partial_net_config_valid_i = 1'b1;
    load(4'h9);
    cmd(CMD_SLEEP);
    bus_wake_pattern_i = 1'b1;
    tick(6);
    md("pat", OMSM_SLEEP);
    bus_wake_frame_i = 1'b1;
    tick(6);
    md("frm", OMSM_STANDBY);
    {bus_wake_pattern_i, bus_wake_frame_i} = 2'b00;
    wclr();
    load(4'h2);
    cmd(CMD_SLEEP);
    local_wake_i = 1'b1;
    tick(6);
    chk("lw", 8'h02, 8'(wake_pending_o));
    md("lw", OMSM_STANDBY);
    local_wake_i = 1'b0;
    wclr();
    $display("test wake done");
    load(4'h1);
    vcc_uv_i = 1'b1;
    tick(8);
    md("uv", OMSM_SLEEP);
    v = {bus_wake_enable_o, local_wake_falling_enable_o,
         local_wake_rising_enable_o, partial_net_enable_o};
    chk("en", 8'h0e, 8'(v));
    rd(ADDR_MAIN_STATUS);
    chk("st", 8'h80, q);
    {vcc_uv_i, io_supply_uv_i} = 2'b01;
    cmd(CMD_STANDBY);
    md("vio", OMSM_SLEEP);
    io_supply_uv_i = 1'b0;
    tick(4);
    cmd(CMD_STANDBY);
    md("vio", OMSM_STANDBY);
    cmd(CMD_SLEEP);
    md("resleep", OMSM_SLEEP);
    chk("cause", 8'h00, 8'(sleep_cause_flag_o));
    cmd(CMD_STANDBY);
    md("resleep", OMSM_STANDBY);
    otp_warning_i = 1'b1;
    tick(5);
    chk("ows", 8'h01, 8'(overtemp_warning_state_o));
    chk("ow", 8'h00, 8'(overtemp_warning_event_o));
    {otp_warning_i, overtemp_warning_irq_enable_i} = 2'b01;
    tick(5);
    otp_warning_i = 1'b1;
    tick(5);
    chk("ow", 8'h01, 8'(overtemp_warning_event_o));
    {otp_warning_i, overtemp_warning_clear_i} = 2'b01;
    tick(1);
    overtemp_warning_clear_i = 1'b0;
    chk("owclr", 8'h00, 8'(overtemp_warning_event_o));
    cmd(CMD_NORMAL);
    otp_activate_i = 1'b1;
    tick(5);
    md("ot", OMSM_OVERTEMP);
    chk("can", 8'h00, 8'(can_active_o));
    chk("bias", 8'h00, 8'(can_bias_o));
    chk("inh", 8'h01, 8'(regulator_inhibit_output_oe_o));
    cmd(CMD_STANDBY);
    md("ot", OMSM_OVERTEMP);
    {otp_activate_i, otp_release_i} = 2'b01;
    tick(6);
    md("rel", OMSM_STANDBY);
    otp_release_i = 1'b0;
    cmd(CMD_NORMAL);
    otp_activate_i = 1'b1;
    tick(5);
    battery_supply_low_i = 1'b1;
    tick(6);
    md("bat", OMSM_OFF);
    chk("inh", 8'h00, 8'(regulator_inhibit_output_oe_o));
    {battery_supply_low_i, otp_activate_i} = 2'b00;
    tick(STARTUP_CYC + 20);
    md("boot", OMSM_STANDBY);
    $display("test power done");
    final_report();
  end
endmodule

`default_nettype wire
